/* File: rtl/pfm_pkg.sv */
// Package for the pin function select multiplexer: pin indices, field layout,
// function selection codes and the list of peripheral functions.
// Assumes one control register per pin, laid out one word apart on APB.
package pfm_pkg;

  localparam int NUM_PINS = 35;
  localparam int NUM_IRQ = 5;
  localparam int CTRL_W = 8;
  localparam int FIELD_W = 6;
  localparam int CODE_W_LARGE = 6;
  localparam int CODE_W_SMALL = 5;
  localparam int INT_SEL_BIT = 6;
  localparam int ANA_SEL_BIT = 7;
  localparam int REG_WORD_SHIFT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // Pin index, equal to the register's word index on the bus
  localparam logic [5:0] PIN_0_0 = 6'h00;
  localparam logic [5:0] PIN_1_2 = 6'h05;
  localparam logic [5:0] PIN_1_3 = 6'h06;
  localparam logic [5:0] PIN_1_4 = 6'h07;
  localparam logic [5:0] PIN_1_5 = 6'h08;
  localparam logic [5:0] PIN_1_6 = 6'h09;
  localparam logic [5:0] PIN_1_7 = 6'h0a;
  localparam logic [5:0] PIN_2_0 = 6'h0b;
  localparam logic [5:0] PIN_2_1 = 6'h0c;
  localparam logic [5:0] PIN_2_6 = 6'h11;
  localparam logic [5:0] PIN_2_7 = 6'h12;
  localparam logic [5:0] PIN_3_0 = 6'h13;
  localparam logic [5:0] PIN_3_1 = 6'h14;
  localparam logic [5:0] PIN_3_2 = 6'h15;
  localparam logic [5:0] PIN_3_4 = 6'h17;
  localparam logic [5:0] PIN_5_4 = 6'h1c;
  localparam logic [5:0] PIN_5_5 = 6'h1d;
  localparam logic [5:0] PIN_A_0 = 6'h1f;
  localparam logic [5:0] PIN_A_1 = 6'h20;
  localparam logic [5:0] PIN_A_2 = 6'h21;
  localparam logic [5:0] PIN_A_3 = 6'h22;

  // Function selection codes
  localparam logic [5:0] CODE_HIZ = 6'h00;
  localparam logic [5:0] CODE_GRP7 = 6'h07;
  localparam logic [5:0] CODE_TMR_ALT = 6'h08;
  localparam logic [5:0] CODE_TRIG = 6'h09;
  localparam logic [5:0] CODE_SER_A = 6'h0a;
  localparam logic [5:0] CODE_SER_B = 6'h0b;
  localparam logic [5:0] CODE_SER_C = 6'h0c;
  localparam logic [5:0] CODE_SPI = 6'h0d;
  localparam logic [5:0] CODE_I2C = 6'h0f;
  localparam logic [5:0] CODE_CAN = 6'h10;
  localparam logic [5:0] CODE_TOUCH = 6'h19;
  localparam logic [5:0] CODE_LPT = 6'h1b;
  localparam logic [5:0] CODE_CMP = 6'h1e;
  localparam logic [5:0] CODE_OD_HI = 6'h21;
  localparam logic [5:0] CODE_TMR_HI = 6'h27;

  localparam int NUM_FN = 38;
  typedef enum logic [5:0] {
    FN_NONE = 6'h00, FN_I2C0_SCL = 6'h01, FN_I2C0_SDA = 6'h02, FN_I2C2_SCL = 6'h03,
    FN_I2C2_SDA = 6'h04, FN_SER0_TX = 6'h05, FN_SER0_RX = 6'h06, FN_SER0_CLK = 6'h07,
    FN_SER1_RX = 6'h08, FN_SER1_FLOW = 6'h09, FN_SER2_RX = 6'h0a, FN_SER2_TX = 6'h0b,
    FN_SER2_FLOW = 6'h0c, FN_SER3_RX = 6'h0d, FN_SER3_TX = 6'h0e, FN_SER3_FLOW = 6'h0f,
    FN_SER6_CLK = 6'h10, FN_SER7_TX = 6'h11, FN_SER12_CLK = 6'h12, FN_SER12_RX = 6'h13,
    FN_SPI_MOSI = 6'h14, FN_SPI_SSL2 = 6'h15, FN_CONV_TRIG = 6'h16, FN_CAN_TX = 6'h17,
    FN_CAN_RX = 6'h18, FN_TMR3_B = 6'h19, FN_TMR4_A = 6'h1a, FN_TMR4_B = 6'h1b,
    FN_TMR4_D = 6'h1c, FN_TMR6_D = 6'h1d, FN_TMR7_A = 6'h1e, FN_OUT_DIS0 = 6'h1f,
    FN_OUT_DIS10 = 6'h20, FN_CMP2_OUT = 6'h21, FN_CMP3_OUT = 6'h22, FN_CAL_CLK_OUT = 6'h23,
    FN_LP_TIMER_OUT = 6'h24, FN_TOUCH = 6'h25
  } pfm_fn_e;

  // Port 3 pins 0..4 feed request lines 0..4 in order; others feed none
  function automatic int irq_line_of(input int pin);
    if (pin >= int'(PIN_3_0) && pin <= int'(PIN_3_4)) begin
      return pin - int'(PIN_3_0);
    end
    return -1;
  endfunction

endpackage

/* File: rtl/pfm_pin_decode.sv */
// Per-pin decoder: turns a pin's function selection code into a function id.
// Assumes the code arrives already masked to the implemented field width.
`timescale 1ns/10ps
`default_nettype none
module pfm_pin_decode
  import pfm_pkg::*;
#(
  parameter logic [5:0] PIN = 6'h00,
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit HAS_SUBCLOCK = 1'b1
) (
  input wire logic [FIELD_W-1:0] func_code,
  output pfm_fn_e fn
);

  always_comb begin
    fn = FN_NONE;
    if (LARGE_VARIANT) begin
      case ({PIN, func_code})
        {PIN_1_2, CODE_SER_A}: fn = FN_SER2_RX;
        {PIN_1_2, CODE_I2C}: fn = FN_I2C0_SCL;
        {PIN_1_3, CODE_SER_A}: fn = FN_SER2_TX;
        {PIN_1_3, CODE_I2C}: fn = FN_I2C0_SDA;
        {PIN_1_4, CODE_CAN}: fn = FN_CAN_TX;
        {PIN_1_5, CODE_CAN}: fn = FN_CAN_RX;
        {PIN_1_6, CODE_GRP7}: fn = HAS_SUBCLOCK ? FN_CAL_CLK_OUT : FN_NONE;
        {PIN_1_6, CODE_TRIG}: fn = FN_CONV_TRIG;
        {PIN_1_6, CODE_SER_B}: fn = FN_SER3_RX;
        {PIN_1_6, CODE_SPI}: fn = FN_SPI_MOSI;
        {PIN_1_6, CODE_I2C}: fn = FN_I2C2_SCL;
        {PIN_1_7, CODE_TMR_ALT}: fn = FN_TMR4_B;
        {PIN_1_7, CODE_SER_B}: fn = FN_SER3_TX;
        {PIN_1_7, CODE_I2C}: fn = FN_I2C2_SDA;
        {PIN_1_7, CODE_CMP}: fn = FN_CMP2_OUT;
        {PIN_2_0, CODE_SER_A}: fn = FN_SER0_TX;
        {PIN_2_1, CODE_TMR_ALT}: fn = FN_TMR4_A;
        {PIN_2_1, CODE_SER_A}: fn = FN_SER0_RX;
        {PIN_2_6, CODE_SER_B}: fn = FN_SER3_FLOW;
        {PIN_3_0, CODE_SER_A}: fn = FN_SER1_RX;
        {PIN_3_0, CODE_CMP}: fn = FN_CMP3_OUT;
        {PIN_3_1, CODE_SER_A}: fn = FN_SER1_FLOW;
        {PIN_3_2, CODE_GRP7}: fn = HAS_SUBCLOCK ? FN_CAL_CLK_OUT : FN_NONE;
        {PIN_3_2, CODE_TMR_ALT}: fn = FN_OUT_DIS0;
        {PIN_3_2, CODE_SER_B}: fn = FN_SER0_TX;
        {PIN_3_2, CODE_CAN}: fn = FN_CAN_TX;
        {PIN_3_2, CODE_OD_HI}: fn = FN_OUT_DIS10;
        {PIN_3_4, CODE_GRP7}: fn = FN_OUT_DIS10;
        {PIN_3_4, CODE_SER_A}: fn = FN_SER6_CLK;
        {PIN_3_4, CODE_SER_B}: fn = FN_SER0_CLK;
        {PIN_5_4, CODE_SER_B}: fn = FN_SER2_FLOW;
        {PIN_5_4, CODE_CAN}: fn = FN_CAN_TX;
        {PIN_5_5, CODE_SER_A}: fn = FN_SER7_TX;
        {PIN_5_5, CODE_CAN}: fn = FN_CAN_RX;
        {PIN_A_0, CODE_TMR_ALT}: fn = FN_TMR6_D;
        {PIN_A_1, CODE_TRIG}: fn = FN_CONV_TRIG;
        {PIN_A_1, CODE_SER_C}: fn = FN_SER12_CLK;
        {PIN_A_1, CODE_SPI}: fn = FN_SPI_SSL2;
        {PIN_A_1, CODE_TMR_HI}: fn = FN_TMR3_B;
        {PIN_A_2, CODE_TMR_ALT}: fn = FN_TMR7_A;
        {PIN_A_2, CODE_SER_C}: fn = FN_SER12_RX;
        {PIN_A_3, CODE_TMR_HI}: fn = FN_TMR4_D;
        default: fn = FN_NONE;
      endcase
    end else begin
      case ({PIN, func_code})
        {PIN_1_2, CODE_I2C}, {PIN_1_6, CODE_I2C}: fn = FN_I2C0_SCL;
        {PIN_1_3, CODE_I2C}, {PIN_1_7, CODE_I2C}: fn = FN_I2C0_SDA;
        {PIN_1_6, CODE_GRP7}, {PIN_3_2, CODE_GRP7}:
          fn = HAS_SUBCLOCK ? FN_CAL_CLK_OUT : FN_NONE;
        {PIN_1_6, CODE_TRIG}: fn = FN_CONV_TRIG;
        {PIN_1_6, CODE_SPI}: fn = FN_SPI_MOSI;
        {PIN_1_4, CODE_CAN}, {PIN_5_4, CODE_CAN}: fn = FN_CAN_TX;
        {PIN_1_5, CODE_CAN}, {PIN_5_5, CODE_CAN}: fn = FN_CAN_RX;
        {PIN_2_6, CODE_LPT}: fn = FN_LP_TIMER_OUT;
        {PIN_1_4, CODE_TOUCH}, {PIN_1_5, CODE_TOUCH}, {PIN_2_6, CODE_TOUCH},
        {PIN_2_7, CODE_TOUCH}, {PIN_3_0, CODE_TOUCH}, {PIN_3_1, CODE_TOUCH},
        {PIN_3_2, CODE_TOUCH}, {PIN_5_4, CODE_TOUCH}, {PIN_5_5, CODE_TOUCH},
        {PIN_A_0, CODE_TOUCH}, {PIN_A_1, CODE_TOUCH}, {PIN_A_2, CODE_TOUCH},
        {PIN_A_3, CODE_TOUCH}: fn = FN_TOUCH;
        default: fn = FN_NONE;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: rtl/pfm_mux.sv */
// Pin function select multiplexer: per-pin control registers on APB, and the
// routing of peripheral signals to and from the pins that they select.
// Assumes pins and peripheral signals are synchronous to pclk; direction and
// mode of each pin are kept by the port logic outside this block.
//
// Overview of operation
// - Code field six bits large, five bits small
// - Zero code leaves pin high impedance, unconnected
// - Interrupt select bit gates pin onto request line
// - Analog select bit connects pin to analog function
// - Port 3 pins feed their assigned request lines
// - Port 1 pins 2,3: I2C0 or serial 2
// - Port 1 pin 6 trigger, serial3, SPI, I2C2
// - Port 1 pin 7 timer, serial3, I2C2, comparator
// - CAN code on port 1 and 5 pins
// - Port 3 pin 2 disable inputs, serial0, CAN
// - Port 3 pin 4 disable10, serial6/0 clocks
// - Port 2 pins 0,1 serial0 and timer 4A
// - Port A pin 1 four functions
// - Port A pins 0,2,3 timer and serial12
// - Calendar output absent without sub-clock oscillator
// - Small variant touch, low-power timer, CAN codes
// - Serial flow control and serial7 transmit
// - Port 3 pins 0,1 comparator3, serial1
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module pfm_mux
  import pfm_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter bit HAS_SUBCLOCK = 1'b1,
  parameter int APB_AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [NUM_PINS-1:0] pin_in,
  output logic [NUM_PINS-1:0] pin_out,
  output logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_FN-1:0] fn_out,
  input wire logic [NUM_FN-1:0] fn_drive,
  output logic [NUM_FN-1:0] fn_in,
  input wire logic [NUM_PINS-1:0] touch_out,
  input wire logic [NUM_PINS-1:0] touch_drive,
  output logic [NUM_PINS-1:0] touch_in,
  output logic [NUM_IRQ-1:0] irq_req,
  output logic [NUM_PINS-1:0] analog_en
);

  // Only the implemented part of the code field is stored; the rest reads zero
  localparam int CODE_W = LARGE_VARIANT ? CODE_W_LARGE : CODE_W_SMALL;
  localparam logic [CTRL_W-1:0] WR_MASK = CTRL_W'((1 << CODE_W) - 1)
                                        | (CTRL_W'(1) << INT_SEL_BIT)
                                        | (CTRL_W'(1) << ANA_SEL_BIT);

  typedef struct packed {
    logic [NUM_PINS-1:0][CTRL_W-1:0] ctrl;
    logic [31:0] rdata;
    logic [NUM_PINS-1:0] pin_out;
    logic [NUM_PINS-1:0] pin_oe_n;
    logic [NUM_FN-1:0] fn_in;
    logic [NUM_PINS-1:0] touch_in;
    logic [NUM_IRQ-1:0] irq;
    logic [NUM_PINS-1:0] analog_en;
  } pfm_state_s;

  localparam pfm_state_s STATE_RESET = '{
    ctrl: {NUM_PINS{CTRL_RESET}},
    rdata: '0,
    pin_out: '0,
    pin_oe_n: '1,
    fn_in: '0,
    touch_in: '0,
    irq: '0,
    analog_en: '0
  };

  pfm_state_s cur;
  pfm_state_s next_state;
  pfm_fn_e fn_sel [NUM_PINS];
  logic [APB_AW-3:0] word_idx;
  logic mapped;
  logic wr_access;
  logic setup_phase;

  assign word_idx = paddr[APB_AW-1:REG_WORD_SHIFT];
  assign mapped = (paddr[REG_WORD_SHIFT-1:0] == '0) && (int'(word_idx) < NUM_PINS);
  assign wr_access = psel && penable && pwrite && mapped && pstrb[0];
  assign setup_phase = psel && !penable;

  // Zero wait states; an unmapped address is flagged in the access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = cur.rdata;
  assign pin_out = cur.pin_out;
  assign pin_oe_n = cur.pin_oe_n;
  assign fn_in = cur.fn_in;
  assign touch_in = cur.touch_in;
  assign irq_req = cur.irq;
  assign analog_en = cur.analog_en;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      pfm_pin_decode #(
        .PIN(6'(gi)),
        .LARGE_VARIANT(LARGE_VARIANT),
        .HAS_SUBCLOCK(HAS_SUBCLOCK)
      ) u_decode (
        .func_code(cur.ctrl[gi][FIELD_W-1:0]),
        .fn(fn_sel[gi])
      );
    end
  endgenerate

  always_comb begin
    pfm_fn_e sel;
    logic drive;
    logic dout;
    logic ana;
    int line;
    sel = FN_NONE;
    drive = 1'b0;
    dout = 1'b0;
    ana = 1'b0;
    line = -1;
    next_state = cur;
    // Masking on write keeps unimplemented code bits at zero
    if (wr_access) begin
      next_state.ctrl[word_idx] = pwdata[CTRL_W-1:0] & WR_MASK;
    end
    // Read data is captured in the setup phase so that it is stable in access
    if (setup_phase) begin
      next_state.rdata = (mapped && !pwrite) ? {24'h000000, cur.ctrl[word_idx]} : '0;
    end
    next_state.fn_in = '0;
    next_state.touch_in = '0;
    next_state.irq = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      sel = fn_sel[i];
      ana = cur.ctrl[i][ANA_SEL_BIT];
      drive = 1'b0;
      dout = 1'b0;
      next_state.analog_en[i] = ana;
      // Analog use takes the pin away from every peripheral and touch function, but not from its request line
      if (!ana && sel != FN_NONE) begin
        if (sel == FN_TOUCH) begin
          drive = touch_drive[i];
          dout = touch_out[i];
          next_state.touch_in[i] = pin_in[i];
        end else begin
          drive = fn_drive[sel];
          dout = fn_out[sel];
          next_state.fn_in[sel] = next_state.fn_in[sel] | pin_in[i];
        end
      end
      next_state.pin_oe_n[i] = !drive;
      next_state.pin_out[i] = drive & dout;
      line = irq_line_of(i);
      if (line >= 0 && cur.ctrl[i][INT_SEL_BIT]) begin
        next_state.irq[line] = next_state.irq[line] | pin_in[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= STATE_RESET;
    end else begin
      cur <= next_state;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_chk
      property p_hiz_zero;
        (cur.ctrl[gi][FIELD_W-1:0] == CODE_HIZ) |=> (pin_oe_n[gi] && !pin_out[gi]);
      endproperty
      a_hiz_zero: assert property (p_hiz_zero)
        else $error("zero code did not leave the pin undriven");
    end
  endgenerate

  // A read of the same word after one idle cycle returns the masked write
  property p_readback;
    (psel && penable && pwrite && mapped && pstrb[0]) ##1 !psel
      ##1 (psel && !penable && !pwrite && paddr == $past(paddr, 2))
      |=> (prdata == ($past(pwdata, 3) & {24'h000000, WR_MASK}));
  endproperty
  a_readback: assert property (p_readback)
    else $error("register read back differs from masked write data");

  property p_irq_off;
    (!cur.ctrl[PIN_3_0][INT_SEL_BIT]) |=> !irq_req[0];
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("request line 0 raised while its pin is not selected");

  property p_irq_route;
    (cur.ctrl[PIN_3_4][INT_SEL_BIT] && pin_in[PIN_3_4])[*2] |=> irq_req[4] ##0 irq_req[4];
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("port 3 pin 4 did not reach request line 4");

  property p_analog;
    cur.ctrl[PIN_A_3][ANA_SEL_BIT] |=> (analog_en[PIN_A_3] && pin_oe_n[PIN_A_3]);
  endproperty
  a_analog: assert property (p_analog)
    else $error("analog selection did not isolate the pin");

  property p_i2c0_clock;
    (cur.ctrl[PIN_1_2][FIELD_W-1:0] == CODE_I2C && !cur.ctrl[PIN_1_2][ANA_SEL_BIT]
      && fn_drive[FN_I2C0_SCL])
      |=> (!pin_oe_n[PIN_1_2] && pin_out[PIN_1_2] == $past(fn_out[FN_I2C0_SCL]));
  endproperty
  a_i2c0_clock: assert property (p_i2c0_clock)
    else $error("I2C channel 0 clock not driven onto port 1 pin 2");

  property p_can_rx;
    (cur.ctrl[PIN_1_5][FIELD_W-1:0] == CODE_CAN && !cur.ctrl[PIN_1_5][ANA_SEL_BIT]
      && cur.ctrl[PIN_5_5][FIELD_W-1:0] != CODE_CAN)
      |=> (fn_in[FN_CAN_RX] == $past(pin_in[PIN_1_5]));
  endproperty
  a_can_rx: assert property (p_can_rx)
    else $error("CAN receive does not follow port 1 pin 5");

  property p_od10;
    (LARGE_VARIANT && cur.ctrl[PIN_3_2][FIELD_W-1:0] == CODE_OD_HI
      && !cur.ctrl[PIN_3_2][ANA_SEL_BIT] && cur.ctrl[PIN_3_4][FIELD_W-1:0] != CODE_GRP7)
      |=> (fn_in[FN_OUT_DIS10] == $past(pin_in[PIN_3_2]));
  endproperty
  a_od10: assert property (p_od10)
    else $error("disable input 10 does not follow port 3 pin 2");

  property p_no_calendar;
    (!HAS_SUBCLOCK && cur.ctrl[PIN_1_6][FIELD_W-1:0] == CODE_GRP7) |=> pin_oe_n[PIN_1_6];
  endproperty
  a_no_calendar: assert property (p_no_calendar)
    else $error("calendar output driven without a sub-clock oscillator");

  property p_unassigned;
    (cur.ctrl[PIN_0_0][FIELD_W-1:0] != CODE_HIZ) |=> (pin_oe_n[PIN_0_0] && !pin_out[PIN_0_0]);
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("unassigned code connected a function to a pin");

endmodule
`default_nettype wire

/* File: bench/pfm_pin_model.sv */
// External pin model for the pin function select multiplexer.
// Assumes the bench chooses which pins an outside source drives and to what level.
`timescale 1ns/10ps
`default_nettype none
module pfm_pin_model
  import pfm_pkg::*;
(
  input wire logic pclk,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] ext_en,
  input wire logic [NUM_PINS-1:0] ext_val,
  output logic [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] churn = '0;

  // Floating pins change every cycle so that a stale level never passes for a real one
  always @(posedge pclk) begin
    churn <= ~churn;
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_in[i] = !pin_oe_n[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : churn[i]);
    end
  end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the pin function select multiplexer.
// Assumes zero-wait APB and one registered stage on every routing path.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import pfm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, analog_en, touch_in;
  logic [NUM_PINS-1:0] ext_en = '0;
  logic [NUM_PINS-1:0] ext_val = '0;
  logic [NUM_FN-1:0] fn_out = '0;
  logic [NUM_FN-1:0] fn_drive = '0;
  logic [NUM_FN-1:0] fn_in;
  logic [NUM_IRQ-1:0] irq_req;
  logic [31:0] rdat;
  logic rerr;
  logic [31:0] prdata_s;
  logic [31:0] rdat_s;
  logic [NUM_PINS-1:0] pin_out_s, pin_oe_n_s, touch_in_s;
  logic [NUM_PINS-1:0] touch_out = '0;
  logic [NUM_PINS-1:0] touch_drive = '0;
  logic [NUM_FN-1:0] fn_in_s;
  int failures = 0;
  int n_checks = 0;

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Sub-clock absent, so the calendar output codes must stay dead
  pfm_mux #(.LARGE_VARIANT(1'b1), .HAS_SUBCLOCK(1'b0), .APB_AW(8)) pfm_mux_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .fn_out(fn_out), .fn_drive(fn_drive), .fn_in(fn_in), .touch_out(touch_out),
    .touch_drive(touch_drive), .touch_in(touch_in), .irq_req(irq_req), .analog_en(analog_en));

  // Small variant with a sub-clock; its pins read the outside level directly
  pfm_mux #(.LARGE_VARIANT(1'b0), .HAS_SUBCLOCK(1'b1), .APB_AW(8)) pfm_mux_small_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(), .prdata(prdata_s),
    .pslverr(), .pin_in(ext_val), .pin_out(pin_out_s), .pin_oe_n(pin_oe_n_s),
    .fn_out(fn_out), .fn_drive(fn_drive), .fn_in(fn_in_s), .touch_out(touch_out),
    .touch_drive(touch_drive), .touch_in(touch_in_s), .irq_req(), .analog_en());

  pfm_pin_model pfm_pin_model_i (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  task automatic close_out();
    if (failures == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_reg({31'h0, got}, {31'h0, exp});
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdat = prdata;
    rdat_s = prdata_s;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic er);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk_reg(rdat, e);
    chk_bit(rerr, er);
  endtask

  // v = {drive, out, outside source on, outside level}; then let routing settle
  task automatic set_io(input int f, input int p, input logic [3:0] v);
    @(posedge pclk);
    fn_drive[f] <= v[3];
    fn_out[f] <= v[2];
    ext_en[p] <= v[1];
    ext_val[p] <= v[0];
    repeat (3) @(posedge pclk);
    #1;
  endtask

  // dir bit 1: peripheral drives the pin; dir bit 0: pin feeds the peripheral
  task automatic route(input logic [5:0] pin, input logic [5:0] code, input pfm_fn_e fn,
                       input logic [1:0] dir);
    int p;
    int f;
    p = int'(pin);
    f = int'(fn);
    wr({pin, 2'b00}, {26'h0, code});
    if (dir[1]) begin
      set_io(f, p, 4'b1100);
      chk_bit(pin_oe_n[p], 1'b0);
      chk_bit(pin_out[p], 1'b1);
      set_io(f, p, 4'b1000);
      chk_bit(pin_out[p], 1'b0);
    end
    if (dir[0]) begin
      set_io(f, p, 4'b0011);
      chk_bit(fn_in[f], 1'b1);
      set_io(f, p, 4'b0010);
      chk_bit(fn_in[f], 1'b0);
    end
    wr({pin, 2'b00}, 32'h0);
    set_io(f, p, 4'b1111);
    chk_bit(pin_oe_n[p], 1'b1);
    chk_bit(fn_in[f], 1'b0);
    set_io(f, p, 4'b0000);
  endtask

  initial begin
    #100us;
    failures++;
    close_out();
  end

  initial begin
    int p;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    chk_bit(&pin_oe_n, 1'b1);
    chk_bit(|irq_req, 1'b0);
    // Direction and mode bits live outside; pins are taken as general inputs
    for (int i = 0; i < NUM_PINS; i++) begin
      rd(8'(i * 4), 32'h0, 1'b0);
      wr(8'(i * 4), 32'hffff_ff00 | 32'(i + 8'h80));
      rd(8'(i * 4), 32'(i + 8'h80), 1'b0);
      wr(8'(i * 4), 32'h0);
    end
    rd(8'h8c, 32'h0, 1'b1);
    p = int'(PIN_1_2);
    wr(8'(p * 4), 32'hffff_ff2f);
    xfer(1'b1, 8'(p * 4), 32'h0f, 4'he);
    xfer(1'b1, 8'(p * 4 + 1), 32'h0f, 4'hf);
    rd(8'(p * 4), 32'h2f, 1'b0);
    rd(8'(p * 4 + 1), 32'h0, 1'b1);
    wr(8'h00, 32'h3f);
    set_io(int'(FN_I2C0_SCL), p, 4'b1111);
    chk_bit(pin_oe_n[p], 1'b1);
    chk_bit(pin_oe_n[0], 1'b1);
    chk_bit(fn_in[FN_I2C0_SCL], 1'b0);
    set_io(int'(FN_I2C0_SCL), p, 4'b0000);
    wr(8'(p * 4), 32'h0);
    wr(8'h00, 32'h0);
    route(PIN_1_2, CODE_I2C, FN_I2C0_SCL, 2'd3);
    route(PIN_1_3, CODE_I2C, FN_I2C0_SDA, 2'd3);
    route(PIN_1_2, CODE_SER_A, FN_SER2_RX, 2'd1);
    route(PIN_1_3, CODE_SER_A, FN_SER2_TX, 2'd2);
    route(PIN_1_6, CODE_TRIG, FN_CONV_TRIG, 2'd1);
    route(PIN_1_6, CODE_SER_B, FN_SER3_RX, 2'd1);
    route(PIN_1_6, CODE_SPI, FN_SPI_MOSI, 2'd3);
    route(PIN_1_6, CODE_I2C, FN_I2C2_SCL, 2'd3);
    route(PIN_1_7, CODE_TMR_ALT, FN_TMR4_B, 2'd3);
    route(PIN_1_7, CODE_SER_B, FN_SER3_TX, 2'd2);
    route(PIN_1_7, CODE_I2C, FN_I2C2_SDA, 2'd3);
    route(PIN_1_7, CODE_CMP, FN_CMP2_OUT, 2'd2);
    route(PIN_1_4, CODE_CAN, FN_CAN_TX, 2'd2);
    route(PIN_5_4, CODE_CAN, FN_CAN_TX, 2'd2);
    route(PIN_1_5, CODE_CAN, FN_CAN_RX, 2'd1);
    route(PIN_5_5, CODE_CAN, FN_CAN_RX, 2'd1);
    route(PIN_3_2, CODE_TMR_ALT, FN_OUT_DIS0, 2'd1);
    route(PIN_3_2, CODE_SER_B, FN_SER0_TX, 2'd2);
    route(PIN_3_2, CODE_CAN, FN_CAN_TX, 2'd2);
    route(PIN_3_2, CODE_OD_HI, FN_OUT_DIS10, 2'd1);
    route(PIN_3_4, CODE_GRP7, FN_OUT_DIS10, 2'd1);
    route(PIN_3_4, CODE_SER_A, FN_SER6_CLK, 2'd3);
    route(PIN_3_4, CODE_SER_B, FN_SER0_CLK, 2'd3);
    route(PIN_2_0, CODE_SER_A, FN_SER0_TX, 2'd2);
    route(PIN_2_1, CODE_SER_A, FN_SER0_RX, 2'd1);
    route(PIN_2_1, CODE_TMR_ALT, FN_TMR4_A, 2'd3);
    route(PIN_A_1, CODE_TRIG, FN_CONV_TRIG, 2'd1);
    route(PIN_A_1, CODE_SER_C, FN_SER12_CLK, 2'd3);
    route(PIN_A_1, CODE_SPI, FN_SPI_SSL2, 2'd2);
    route(PIN_A_1, CODE_TMR_HI, FN_TMR3_B, 2'd3);
    route(PIN_A_0, CODE_TMR_ALT, FN_TMR6_D, 2'd3);
    route(PIN_A_2, CODE_TMR_ALT, FN_TMR7_A, 2'd3);
    route(PIN_A_2, CODE_SER_C, FN_SER12_RX, 2'd1);
    route(PIN_A_3, CODE_TMR_HI, FN_TMR4_D, 2'd3);
    route(PIN_2_6, CODE_SER_B, FN_SER3_FLOW, 2'd1);
    route(PIN_5_4, CODE_SER_B, FN_SER2_FLOW, 2'd1);
    route(PIN_5_5, CODE_SER_A, FN_SER7_TX, 2'd2);
    route(PIN_3_0, CODE_CMP, FN_CMP3_OUT, 2'd2);
    route(PIN_3_0, CODE_SER_A, FN_SER1_RX, 2'd1);
    route(PIN_3_1, CODE_SER_A, FN_SER1_FLOW, 2'd1);
    for (int k = 0; k < 2; k++) begin
      p = k ? int'(PIN_3_2) : int'(PIN_1_6);
      wr(8'(p * 4), {26'h0, CODE_GRP7});
      set_io(int'(FN_CAL_CLK_OUT), p, 4'b1100);
      chk_bit(pin_oe_n[p], 1'b1);
      set_io(int'(FN_CAL_CLK_OUT), p, 4'b0000);
      wr(8'(p * 4), 32'h0);
    end
    for (int n = 0; n < NUM_IRQ; n++) begin
      p = int'(PIN_3_0) + n;
      wr(8'(p * 4), 32'h40);
      set_io(0, p, 4'b0011);
      chk_reg({27'h0, irq_req}, 32'h1 << n);
      set_io(0, p, 4'b0010);
      chk_reg({27'h0, irq_req}, 32'h0);
      wr(8'(p * 4), 32'h0);
      set_io(0, p, 4'b0011);
      chk_reg({27'h0, irq_req}, 32'h0);
      set_io(0, p, 4'b0000);
    end
    p = int'(PIN_1_7);
    wr(8'(p * 4), 32'h9e);
    set_io(int'(FN_CMP2_OUT), p, 4'b1100);
    chk_bit(analog_en[p], 1'b1);
    chk_bit(pin_oe_n[p], 1'b1);
    wr(8'(p * 4), 32'h1e);
    set_io(int'(FN_CMP2_OUT), p, 4'b1100);
    chk_bit(analog_en[p], 1'b0);
    chk_bit(pin_oe_n[p], 1'b0);
    set_io(int'(FN_CMP2_OUT), p, 4'b0000);
    wr(8'(p * 4), 32'h0);
    // Small variant: five-bit field, low-power timer, touch, CAN, calendar present
    p = int'(PIN_2_6);
    wr(8'(p * 4), 32'h3b);
    rd(8'(p * 4), 32'h3b, 1'b0);
    chk_reg(rdat_s, 32'h1b);
    set_io(int'(FN_LP_TIMER_OUT), p, 4'b1100);
    chk_bit(pin_oe_n_s[p], 1'b0);
    chk_bit(pin_out_s[p], 1'b1);
    chk_bit(pin_oe_n[p], 1'b1);
    set_io(int'(FN_LP_TIMER_OUT), p, 4'b0000);
    wr(8'(p * 4), {26'h0, CODE_TOUCH});
    touch_drive[p] <= 1'b1;
    touch_out[p] <= 1'b1;
    set_io(0, p, 4'b0011);
    chk_bit(pin_oe_n_s[p], 1'b0);
    chk_bit(pin_out_s[p], 1'b1);
    chk_bit(touch_in_s[p], 1'b1);
    chk_bit(pin_oe_n[p], 1'b1);
    touch_drive[p] <= 1'b0;
    touch_out[p] <= 1'b0;
    set_io(0, p, 4'b0000);
    chk_bit(touch_in_s[p], 1'b0);
    chk_bit(pin_oe_n_s[p], 1'b1);
    wr(8'(p * 4), 32'h0);
    p = int'(PIN_1_4);
    wr(8'(p * 4), {26'h0, CODE_CAN});
    set_io(int'(FN_CAN_TX), p, 4'b1101);
    chk_bit(pin_out_s[p], 1'b1);
    chk_bit(fn_in_s[FN_CAN_TX], 1'b1);
    set_io(int'(FN_CAN_TX), p, 4'b0000);
    wr(8'(p * 4), 32'h0);
    p = int'(PIN_1_6);
    wr(8'(p * 4), {26'h0, CODE_GRP7});
    set_io(int'(FN_CAL_CLK_OUT), p, 4'b1100);
    chk_bit(pin_oe_n_s[p], 1'b0);
    chk_bit(pin_oe_n[p], 1'b1);
    set_io(int'(FN_CAL_CLK_OUT), p, 4'b0000);
    wr(8'(p * 4), 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
